// File: design/odac_map.svh
/*
  Constants for the octal converter control block: bus address, command
  codes, clear codes and their values, reset values.
  Assumes inclusion by bare name from any design file that needs them.
*/
`ifndef ODAC_MAP_SVH
`define ODAC_MAP_SVH

// ------------------------------------------------------------
// serial bus address
// ------------------------------------------------------------
`define ODAC_ADDR_UPPER     6'h2a
`define ODAC_ADDR_UPPER_W   6

// ------------------------------------------------------------
// command byte layout and codes
// ------------------------------------------------------------
`define ODAC_CMD_MSB        7
`define ODAC_CMD_LSB        4
`define ODAC_CH_MSB         2
`define ODAC_CH_LSB         0
`define ODAC_CMD_WR_INPUT   4'h0
`define ODAC_CMD_WR_UPDATE  4'h1
`define ODAC_CMD_SET_CLEAR  4'h2
`define ODAC_CMD_REF_CTRL   4'h3

// ------------------------------------------------------------
// clear codes and values
// ------------------------------------------------------------
`define ODAC_CLR_ZERO       2'h0
`define ODAC_CLR_MID        2'h1
`define ODAC_CLR_FULL       2'h2
`define ODAC_VAL_ZERO       16'h0000
`define ODAC_VAL_MID        16'h8000
`define ODAC_VAL_FULL       16'hffff

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ODAC_RST_CLR_CODE   2'h0
`define ODAC_RST_CODE       16'h0000
`define ODAC_RST_REF_EN     1'b0

`endif

// File: design/odac_pkg.sv
/*
  Types shared by the octal converter control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package odac_pkg;

  typedef logic [15:0] odac_code_type;
  typedef logic [2:0]  odac_chan_type;

  typedef enum logic [3:0] {
    ODAC_IDLE   = 4'b0001,
    ODAC_RECV   = 4'b0010,
    ODAC_ACK    = 4'b0100,
    ODAC_IGNORE = 4'b1000
  } odac_state_type;

endpackage

// File: design/odac_chan_if.sv
/*
  Bundle from the serial controller to the eight channel slices.
  Assumes one controller drives it and every slice only listens.
*/
`timescale 1ns/100ps
`default_nettype none

interface odac_chan_if;
  import odac_pkg::*;

  logic          wr_en;
  odac_chan_type wr_ch;
  odac_code_type wr_data;
  logic          wr_update;
  logic          load;
  logic          clear;
  odac_code_type clear_value;

  modport ctrl (output wr_en, wr_ch, wr_data, wr_update, load, clear, clear_value);
  modport chan (input wr_en, wr_ch, wr_data, wr_update, load, clear, clear_value);
endinterface

`default_nettype wire

// File: design/odac_channel.sv
/*
  One converter channel: input register, converter register, pending flag.
  Assumes the controller's write and clear strobes are one cycle wide and on clk; load is a level.
*/
`timescale 1ns/100ps
`default_nettype none
`include "odac_map.svh"

module odac_channel
  import odac_pkg::*;
#(
  parameter odac_chan_type IDX = 3'h0
) (
  input  wire logic     clk,
  input  wire logic     reset,
  odac_chan_if.chan     bus,
  output odac_code_type dac_code_ff
);

  odac_code_type input_ff;
  logic          pending_ff;
  logic          hit;

  assign hit = bus.wr_en && (bus.wr_ch == IDX);

  // ------------------------------------------------------------
  // input register and pending flag
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      input_ff   <= `ODAC_RST_CODE;
      pending_ff <= 1'b0;
    end else if (bus.clear) begin
      // RULE_06 clear loads input
      input_ff   <= bus.clear_value;
      pending_ff <= 1'b0;
    end else if (hit) begin
      input_ff   <= bus.wr_data;
      pending_ff <= !bus.wr_update;
    end else if (bus.load) begin
      pending_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // converter register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      dac_code_ff <= `ODAC_RST_CODE;
    end else if (bus.clear) begin
      // RULE_06 clear loads converter
      dac_code_ff <= bus.clear_value;
    end else if (hit && bus.wr_update) begin
      dac_code_ff <= bus.wr_data;
    end else if (bus.load && pending_ff) begin
      // RULE_01 copy pending data
      dac_code_ff <= input_ff;
    end
  end

endmodule

`default_nettype wire

// File: design/odac_top.sv
/*
  Octal converter control: two-wire serial slave, 32-bit shift register,
  load strobe update, asynchronous clear and reference control.
  Assumes all pins are asynchronous to clk and are synchronised here;
  the bus clock is far slower than clk (sampled, not used as a clock).
*/
// Overview of operation
// RULE_01 - load strobe low copies every pending input register to its converter register
// RULE_02 - the controller may tie the load strobe low instead of pulsing it
// RULE_03 - the address select pin is the slave address least significant bit
// RULE_04 - clear acts on a falling edge of its pin, independent of bus clock
// RULE_05 - while clear is low, load strobe pulses are ignored
// RULE_06 - a clear loads input and converter registers with the chosen clear code
// RULE_07 - after reset the clear code selects zero scale
// RULE_08 - serial data shifts through a 32-bit register on open-drain data line
// RULE_09 - reference pin is an input unless the internal reference is enabled
// RULE_10 - internal reference is off after reset, enabled only by a write
// RULE_11 - channel codes are straight binary
// RULE_12 - controller waits 300 ns after the ninth clock before the load strobe
// RULE_13 - eight independent channels A to H, each with two registers
`timescale 1ns/100ps
`default_nettype none
`include "odac_map.svh"

module odac_top
  import odac_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output logic          sda_out_ff,
  output logic          sda_oe_ff,
  input  wire logic     load_strobe_n,
  input  wire logic     async_clear_in,
  input  wire logic     addr_select_lsb,
  output logic          ref_out_en_ff,
  output odac_code_type analog_out_a,
  output odac_code_type analog_out_b,
  output odac_code_type analog_out_c,
  output odac_code_type analog_out_d,
  output odac_code_type analog_out_e,
  output odac_code_type analog_out_f,
  output odac_code_type analog_out_g,
  output odac_code_type analog_out_h
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic       scl_prev_ff;
  logic       sda_prev_ff;
  logic       clr_prev_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
    end else begin
      meta_ff <= {addr_select_lsb, async_clear_in, load_strobe_n, sda_in, scl_in};
      sync_ff <= meta_ff;
    end
  end

  logic scl_s;
  logic sda_s;
  logic load_n_s;
  logic clr_s;
  logic addr_lsb_s;

  assign {addr_lsb_s, clr_s, load_n_s, sda_s, scl_s} = sync_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      clr_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      clr_prev_ff <= clr_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic clr_fall;

  assign scl_rise   = scl_s && !scl_prev_ff;
  assign scl_fall   = !scl_s && scl_prev_ff;
  assign start_seen = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_seen  = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
  // RULE_04 falling edge trigger
  assign clr_fall   = clr_prev_ff && !clr_s;

  // ------------------------------------------------------------
  // serial slave state machine
  // ------------------------------------------------------------
  odac_state_type state_ff;
  logic [31:0]    shift_ff;
  logic [2:0]     bit_cnt_ff;
  logic [1:0]     byte_idx_ff;
  logic           byte_done_ff;
  logic           match_ff;
  logic           exec_ff;
  logic [7:0]     rx_byte;

  assign rx_byte = {shift_ff[6:0], sda_s};

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff     <= ODAC_IDLE;
      shift_ff     <= 32'h0000_0000;
      bit_cnt_ff   <= 3'h0;
      byte_idx_ff  <= 2'h0;
      byte_done_ff <= 1'b0;
      match_ff     <= 1'b0;
      exec_ff      <= 1'b0;
    end else begin
      exec_ff <= 1'b0;
      if (start_seen) begin
        state_ff     <= ODAC_RECV;
        bit_cnt_ff   <= 3'h0;
        byte_idx_ff  <= 2'h0;
        byte_done_ff <= 1'b0;
      end else if (stop_seen) begin
        state_ff <= ODAC_IDLE;
      end else begin
        unique case (state_ff)
          ODAC_IDLE: begin
            state_ff <= ODAC_IDLE;
          end
          ODAC_RECV: begin
            if (scl_rise) begin
              // RULE_08 shift on bus clock
              shift_ff   <= {shift_ff[30:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == 3'h7) begin
                byte_done_ff <= 1'b1;
                if (byte_idx_ff == 2'h0) begin
                  // RULE_03 address lsb from pin
                  match_ff <= (rx_byte[7:1] == {`ODAC_ADDR_UPPER, addr_lsb_s}) &&
                              !rx_byte[0];
                end
                exec_ff <= (byte_idx_ff == 2'h3);
              end
            end else if (scl_fall && byte_done_ff) begin
              byte_done_ff <= 1'b0;
              state_ff     <= match_ff ? ODAC_ACK : ODAC_IGNORE;
            end
          end
          ODAC_ACK: begin
            if (scl_fall) begin
              state_ff    <= ODAC_RECV;
              byte_idx_ff <= (byte_idx_ff == 2'h3) ? 2'h1 : byte_idx_ff + 2'h1;
            end
          end
          ODAC_IGNORE: begin
            state_ff <= ODAC_IGNORE;
          end
        endcase
      end
    end
  end

  // open-drain: only ever pull low
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_out_ff <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
      if (state_ff == ODAC_RECV && scl_fall && byte_done_ff && match_ff) begin
        sda_oe_ff <= 1'b1;
      end else if ((state_ff == ODAC_ACK && scl_fall) || start_seen || stop_seen) begin
        sda_oe_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // command decode, clear code, reference
  // ------------------------------------------------------------
  logic [3:0]    cmd;
  odac_chan_type cmd_ch;
  logic [1:0]    clr_code_ff;
  logic          wr_en_ff;
  logic          wr_update_ff;
  odac_chan_type wr_ch_ff;
  odac_code_type wr_data_ff;

  assign cmd    = shift_ff[16 + `ODAC_CMD_MSB:16 + `ODAC_CMD_LSB];
  assign cmd_ch = shift_ff[16 + `ODAC_CH_MSB:16 + `ODAC_CH_LSB];

  always_ff @(posedge clk) begin
    if (reset) begin
      // RULE_07 zero scale after reset
      clr_code_ff   <= `ODAC_RST_CLR_CODE;
      // RULE_09 reference pin is input
      // RULE_10 reference off at reset
      ref_out_en_ff <= `ODAC_RST_REF_EN;
    end else if (exec_ff && cmd == `ODAC_CMD_SET_CLEAR) begin
      clr_code_ff <= shift_ff[1:0];
    end else if (exec_ff && cmd == `ODAC_CMD_REF_CTRL) begin
      // RULE_10 enabled by write
      ref_out_en_ff <= shift_ff[0];
    end
  end

  // registered so the channel strobes are clean single cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_en_ff     <= 1'b0;
      wr_update_ff <= 1'b0;
      wr_ch_ff     <= 3'h0;
      wr_data_ff   <= `ODAC_RST_CODE;
    end else begin
      wr_en_ff     <= exec_ff && (cmd == `ODAC_CMD_WR_INPUT || cmd == `ODAC_CMD_WR_UPDATE);
      wr_update_ff <= (cmd == `ODAC_CMD_WR_UPDATE);
      wr_ch_ff     <= cmd_ch;
      // RULE_11 straight binary code
      wr_data_ff   <= shift_ff[15:0];
    end
  end

  // ------------------------------------------------------------
  // channel bundle and slices
  // ------------------------------------------------------------
  odac_chan_if   chan_bus ();
  odac_code_type codes [8];

  assign chan_bus.wr_en     = wr_en_ff;
  assign chan_bus.wr_ch     = wr_ch_ff;
  assign chan_bus.wr_data   = wr_data_ff;
  assign chan_bus.wr_update = wr_update_ff;
  // RULE_04 clear from pin edge
  assign chan_bus.clear     = clr_fall;
  // RULE_02 level sense covers tied low
  // RULE_05 ignored while clear low
  assign chan_bus.load      = !load_n_s && clr_s;
  assign chan_bus.clear_value = (clr_code_ff == `ODAC_CLR_MID)  ? `ODAC_VAL_MID  :
                                (clr_code_ff == `ODAC_CLR_FULL) ? `ODAC_VAL_FULL :
                                `ODAC_VAL_ZERO;

  // RULE_13 eight independent channels
  for (genvar i = 0; i < 8; i++) begin : g_chan
    odac_channel #(
      .IDX (3'(i))
    ) u_chan (
      .clk         (clk),
      .reset       (reset),
      .bus         (chan_bus.chan),
      .dac_code_ff (codes[i])
    );
  end

  assign analog_out_a = codes[0];
  assign analog_out_b = codes[1];
  assign analog_out_c = codes[2];
  assign analog_out_d = codes[3];
  assign analog_out_e = codes[4];
  assign analog_out_f = codes[5];
  assign analog_out_g = codes[6];
  assign analog_out_h = codes[7];

endmodule

`default_nettype wire

// File: verif/odac_assertions.sv
/*
  Checker on the octal converter control top ports.
  Assumes a 100 MHz clk and a bus clock far slower than clk.
*/
`timescale 1ns/100ps
`default_nettype none
module odac_assertions
  import odac_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          scl_in,
  input wire logic          sda_out_ff,
  input wire logic          sda_oe_ff,
  input wire logic          load_strobe_n,
  input wire logic          async_clear_in,
  input wire logic          ref_out_en_ff,
  input wire odac_code_type analog_out_a,
  input wire odac_code_type analog_out_b,
  input wire odac_code_type analog_out_h
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_zero: assert property (
    $fell(reset) |-> analog_out_a == 16'h0000 && analog_out_h == 16'h0000 && !sda_oe_ff)
    else $error("outputs not zero after reset");
  a_ref_off_reset: assert property (
    $fell(reset) |-> !ref_out_en_ff [*8])
    else $error("reference on after reset");
  a_data_open_drain: assert property (
    sda_out_ff == 1'b0)
    else $error("data line driven high");
  a_ack_scl_low: assert property (
    $rose(sda_oe_ff) |-> !scl_in)
    else $error("ack began with bus clock high");
  a_ack_holds_high: assert property (
    $rose(scl_in) && sda_oe_ff |=> sda_oe_ff [*5])
    else $error("ack dropped while bus clock high");
  // sync delay of the pin is at most three cycles, so six is ample
  a_clear_all_equal: assert property (
    $fell(async_clear_in) |-> ##6 analog_out_a == analog_out_h && analog_out_b == analog_out_h
      && analog_out_h inside {16'h0000, 16'h8000, 16'hffff})
    else $error("clear did not set all channels");
  a_clear_blocks_load: assert property (
    (!async_clear_in && scl_in) [*8] |-> $stable(analog_out_a) && $stable(analog_out_h))
    else $error("output moved while clear low");
  a_idle_no_update: assert property (
    (load_strobe_n && async_clear_in && scl_in) [*8] |-> $stable(analog_out_b))
    else $error("output moved without load");
  c_ack: cover property ($rose(sda_oe_ff));
  c_clear_full: cover property ($fell(async_clear_in) ##6 analog_out_a == 16'hffff);
  c_ref_on: cover property ($rose(ref_out_en_ff));
endmodule
bind odac_top odac_assertions chk (.clk(clk), .reset(reset), .scl_in(scl_in),
  .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .load_strobe_n(load_strobe_n),
  .async_clear_in(async_clear_in), .ref_out_en_ff(ref_out_en_ff),
  .analog_out_a(analog_out_a), .analog_out_b(analog_out_b), .analog_out_h(analog_out_h));
`default_nettype wire

// File: verif/odac_bus_master.sv
/*
  Two-wire bus master model: start, bytes with ack, stop.
  Assumes a pull-up on the data wire, worked out by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module odac_bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // quarter bit of 40 ns, bus clock stands high between frames
  task automatic q();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic rd);
    q();
    sda_oe = !b;
    q();
    scl = 1'b1;
    q();
    rd = sda;
    q();
    scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] b [4], input int n, output int acks);
    logic r;
    acks = 0;
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) bit_io(b[i][k], r);
      bit_io(1'b1, r);
      if (r) break;
      acks++;
    end
    q();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
/*
  Self-checking bench for the octal converter control block.
  Assumes the bus master model and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "odac_map.svh"
module tb;
  import odac_pkg::*;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic          load_strobe_n = 1'b1;
  logic          async_clear_in = 1'b1;
  logic          addr_select_lsb = 1'b0;
  logic          scl;
  logic          m_oe;
  logic          sda_out_ff;
  logic          sda_oe_ff;
  logic          ref_out_en_ff;
  wire logic     sda;
  odac_code_type out [8];
  odac_code_type exp [8] = '{default: 16'h0000};
  int            error_cnt = 0;
  int            checked = 0;
  always #5 clk = ~clk;
  // open drain with pull-up
  assign sda = !(m_oe || (sda_oe_ff && !sda_out_ff));
  odac_bus_master bus_master (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  odac_top dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .load_strobe_n(load_strobe_n), .async_clear_in(async_clear_in),
    .addr_select_lsb(addr_select_lsb), .ref_out_en_ff(ref_out_en_ff), .analog_out_a(out[0]),
    .analog_out_b(out[1]), .analog_out_c(out[2]), .analog_out_d(out[3]),
    .analog_out_e(out[4]), .analog_out_f(out[5]), .analog_out_g(out[6]), .analog_out_h(out[7]));
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk_all(input string msg);
    for (int i = 0; i < 8; i++) chk(out[i] === exp[i], msg);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] cmd, input logic [2:0] ch, input logic [15:0] code,
                    input logic lsb, input int n_ack);
    logic [7:0] b [4];
    int acks;
    b = '{{`ODAC_ADDR_UPPER, lsb, 1'b0}, {cmd, 1'b0, ch}, code[15:8], code[7:0]};
    bus_master.send(b, 4, acks);
    chk(acks == n_ack, "ack count");
    cyc(40);
  endtask
  task automatic t_reset();
    chk_all("reset code");
    chk(ref_out_en_ff === 1'b0, "reference default");
  endtask
  task automatic t_addr();
    logic [7:0] b [4];
    int acks;
    for (int l = 0; l < 2; l++) begin
      addr_select_lsb = l[0];
      cyc(4);
      wr(4'h0, 3'h0, 16'h1234, !l[0], 0);
      wr(4'h1, 3'(l), 16'h00a0 + 16'(l), l[0], 4);
      exp[l] = 16'h00a0 + 16'(l);
      chk_all("direct update");
    end
    b = '{{`ODAC_ADDR_UPPER, 1'b1, 1'b1}, 8'h00, 8'h00, 8'h00};
    bus_master.send(b, 1, acks);
    chk(acks == 0, "read refused");
  endtask
  task automatic t_load();
    for (int i = 0; i < 8; i++) wr(4'h0, 3'(i), 16'h1111 * 16'(i + 1), 1'b1, 4);
    chk_all("held before load");
    load_strobe_n = 1'b0;
    cyc(2);
    load_strobe_n = 1'b1;
    cyc(10);
    for (int i = 0; i < 8; i++) exp[i] = 16'h1111 * 16'(i + 1);
    chk_all("load update");
  endtask
  task automatic t_tied();
    load_strobe_n = 1'b0;
    wr(4'h0, 3'h4, 16'hbeef, 1'b1, 4);
    exp[4] = 16'hbeef;
    chk_all("tied load");
    load_strobe_n = 1'b1;
    cyc(4);
  endtask
  task automatic t_ref();
    wr(4'h3, 3'h0, 16'h0001, 1'b1, 4);
    chk(ref_out_en_ff === 1'b1, "reference on");
    wr(4'h3, 3'h0, 16'h0000, 1'b1, 4);
    chk(ref_out_en_ff === 1'b0, "reference off");
  endtask
  // pending data written while clear is low must not reach the outputs
  task automatic t_clear();
    odac_code_type val [3] = '{`ODAC_VAL_ZERO, `ODAC_VAL_MID, `ODAC_VAL_FULL};
    for (int j = 0; j < 3; j++) begin
      if (j > 0) wr(4'h2, 3'h0, 16'(j), 1'b1, 4);
      async_clear_in = 1'b0;
      cyc(10);
      if (j == 0) chk(out[5] === 16'h0000, "default clear");
      exp = '{default: val[j]};
      chk_all("clear value");
      // last channel, so the checker's watch on it sees a missed gate
      wr(4'h0, 3'h7, 16'h5a5a, 1'b1, 4);
      load_strobe_n = 1'b0;
      cyc(2);
      load_strobe_n = 1'b1;
      cyc(10);
      chk_all("load during clear");
      async_clear_in = 1'b1;
      cyc(4);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #900_000;
    error_cnt++;
    $display("unexpected at %0t: run too long", $time);
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    cyc(4);
    t_reset();
    t_addr();
    t_load();
    t_tied();
    t_ref();
    t_clear();
    summarize();
  end
endmodule
`default_nettype wire
